/* design/rx_address_filter_wake_detect.sv */
// destination address filter and wake-up frame detector with avalon-mm registers
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`include "rx_filter_consts.svh"

module rx_address_filter_wake_detect #(
  parameter int NUM_FILTERS = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // receive byte stream from the mac
  input wire logic rx_valid_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  input wire logic [7:0] rx_data_i,
  // power state pin, high in the first low-power state
  input wire logic low_power_i,
  // results
  output logic filt_done_o,
  output logic filt_pass_o,
  output logic irq_o,
  output logic power_event_out_o
);

  rx_filter_pkg::filter_state_type st_ff;
  rx_filter_pkg::filter_state_type nxt_st;

  logic [NUM_FILTERS-1:0][15:0] pat_crc;
  logic [7:0] byte_idx;

  // ethernet crc32 step, data lsb first
  function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0};
      if (fb)
        r = r ^ `CRC32_POLY;
    end
    return r;
  endfunction

  // byte-enable merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  // word select on the register bus; address bits 1:0 are byte lanes and ignored
  function automatic logic reg_sel(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  // wake control/status word as software reads it; low power shows the synced pin
  function automatic logic [31:0] csr_word(input logic en, input logic rcvd, input logic note,
                                           input logic lp, input logic [2:0] ptr);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`WCS_ENABLE] = en;
    r[`WCS_RECEIVED] = rcvd;
    r[`WCS_NOTIFY_PME] = note;
    r[`WCS_LOW_POWER] = lp;
    r[`WCS_PTR_LSB +: 3] = ptr;
    return r;
  endfunction

  // hash table lookup for a six-bit index
  function automatic logic hash_bit(input logic [31:0] hi, input logic [31:0] lo,
                                    input logic [5:0] idx);
    logic r;
    if (idx[5])
      r = hi[idx[4:0]];
    else
      r = lo[idx[4:0]];
    return r;
  endfunction

  // address decision: promiscuous, then multicast pass, then the mode bits;
  // inverse wins over the hash modes when software sets several at once
  function automatic logic mode_pass(input logic [`CTL_WIDTH-1:0] ctl, input logic mcast,
                                     input logic exact, input logic hashed);
    logic r;
    if (ctl[`CTL_INVERSE])
      r = ~exact;
    else if (ctl[`CTL_HASH_ONLY])
      r = hashed;
    else if (ctl[`CTL_HASH_PERFECT])
      r = mcast ? hashed : exact;
    else
      r = exact;
    if (ctl[`CTL_PASS_MCAST] & mcast)
      r = 1'b1;
    if (ctl[`CTL_PROMISC])
      r = 1'b1;
    return r;
  endfunction

  // one wake filter: enabled, right address type and crc equal
  function automatic logic filter_hit(input logic [3:0] cmd, input logic mcast,
                                      input logic [15:0] got, input logic [15:0] want);
    if (!cmd[`CMD_ENABLE])
      return 1'b0;
    // type and crc; reserved bits 2:1 ignored
    return cmd[`CMD_MCAST] == mcast && got == want;
  endfunction

  // frame byte index: a start of frame restarts at zero
  assign byte_idx = rx_sof_i ? 8'h00 : st_ff.byte_cnt;

  // one crc-16 checker per wake filter
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++)
    begin : gen_check
      wake_pattern_check u_check (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .byte_valid_i(rx_valid_i),
        .sof_i(rx_sof_i),
        .byte_i(rx_data_i),
        .byte_idx_i(byte_idx),
        .mask_i(st_ff.wake_words[g][30:0]),
        .offset_i(st_ff.wake_words[`WORD_OFFSET][g*8 +: 8]),
        .crc_o(pat_crc[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic req;
    logic take;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [47:0] da;
    logic [31:0] hcrc;
    logic [5:0] hidx;
    logic mcast;
    logic exact;
    logic hashed;
    logic pass;
    logic wake_mode;
    logic [3:0] cmd;
    logic [15:0] want;
    logic hit;
    // scratch word for narrow register merges
    logic [31:0] mrg;
    req = avs_read_i | avs_write_i;
    take = req & ~st_ff.wait_req;
    wd = avs_writedata_i;
    rd = 32'h0000_0000;
    da = st_ff.dest_addr;
    hcrc = rx_sof_i ? `CRC32_INIT : st_ff.hash_crc;
    hidx = 6'h00;
    mcast = 1'b0;
    exact = 1'b0;
    hashed = 1'b0;
    pass = 1'b0;
    cmd = 4'h0;
    want = 16'h0000;
    hit = 1'b0;
    wake_mode = 1'b0;
    mrg = 32'h0000_0000;
    nxt_st = st_ff;
    nxt_st.filt_done = 1'b0;

    // power pin synchroniser
    nxt_st.lp_meta = low_power_i;
    nxt_st.lp_sync = st_ff.lp_meta;
    wake_mode = st_ff.wake_en | st_ff.lp_sync;

    // waitrequest drops for one cycle in the second cycle of each request
    nxt_st.wait_req = ~(req & st_ff.wait_req);

    // read data prepared while waitrequest is still high; only reads load it,
    // so a write never disturbs data that an earlier read left standing
    if (avs_read_i & st_ff.wait_req)
    begin
      // word decode; unmapped words and the load port read as zero
      if (reg_sel(avs_address_i, `OFS_MAC_CTRL))
        rd[`CTL_WIDTH-1:0] = st_ff.ctrl;
      else if (reg_sel(avs_address_i, `OFS_STA_HIGH))
        rd[15:0] = st_ff.sta_hi;
      else if (reg_sel(avs_address_i, `OFS_STA_LOW))
        rd = st_ff.sta_lo;
      else if (reg_sel(avs_address_i, `OFS_HASH_HIGH))
        rd = st_ff.hash_hi;
      else if (reg_sel(avs_address_i, `OFS_HASH_LOW))
        rd = st_ff.hash_lo;
      else if (reg_sel(avs_address_i, `OFS_WAKE_CSR))
        rd = csr_word(st_ff.wake_en, st_ff.wake_rcvd, st_ff.notify_pme, st_ff.lp_sync,
                      st_ff.load_ptr);
      nxt_st.rdata = rd;
    end

    // writes take effect at the edge where waitrequest is low
    if (take & avs_write_i)
    begin
      // narrow registers merge through a full word, then keep their own bits
      if (reg_sel(avs_address_i, `OFS_MAC_CTRL))
      begin
        mrg = be_merge({27'h0, st_ff.ctrl}, wd, avs_byteenable_i);
        nxt_st.ctrl = mrg[`CTL_WIDTH-1:0];
      end
      else if (reg_sel(avs_address_i, `OFS_STA_HIGH))
      begin
        mrg = be_merge({16'h0, st_ff.sta_hi}, wd, avs_byteenable_i);
        nxt_st.sta_hi = mrg[15:0];
      end
      else if (reg_sel(avs_address_i, `OFS_STA_LOW))
        nxt_st.sta_lo = be_merge(st_ff.sta_lo, wd, avs_byteenable_i);
      else if (reg_sel(avs_address_i, `OFS_HASH_HIGH))
        nxt_st.hash_hi = be_merge(st_ff.hash_hi, wd, avs_byteenable_i);
      else if (reg_sel(avs_address_i, `OFS_HASH_LOW))
        nxt_st.hash_lo = be_merge(st_ff.hash_lo, wd, avs_byteenable_i);
      // the control bits live in lane 0; a write without it changes nothing here
      else if (reg_sel(avs_address_i, `OFS_WAKE_CSR) && avs_byteenable_i[0])
      begin
        // enable enters, clear leaves wake mode
        nxt_st.wake_en = wd[`WCS_ENABLE];
        nxt_st.notify_pme = wd[`WCS_NOTIFY_PME];
        // received flag is write-one-to-clear
        if (wd[`WCS_RECEIVED])
          nxt_st.wake_rcvd = 1'b0;
        // any write here rewinds the load pointer
        nxt_st.load_ptr = 3'h0;
      end
      else if (reg_sel(avs_address_i, `OFS_WAKE_LOAD))
      begin
        nxt_st.wake_words[st_ff.load_ptr] =
          be_merge(st_ff.wake_words[st_ff.load_ptr], wd, avs_byteenable_i);
        if (st_ff.load_ptr < 3'(`WORD_CMD))
          nxt_st.wake_words[st_ff.load_ptr][`MASK_BITS] = 1'b0;
        // the pointer wraps after the last word, ready for the next full load
        nxt_st.load_ptr = st_ff.load_ptr + 3'h1;
      end
    end

    // receive byte path: destination capture and hash crc
    if (rx_valid_i)
    begin
      nxt_st.byte_cnt = (byte_idx == `BYTE_CNT_MAX) ? byte_idx : byte_idx + 8'h01;
      if (rx_sof_i)
        nxt_st.addr_pass = 1'b0;
      if (byte_idx < `DA_BYTES)
      begin
        da[byte_idx[2:0]*8 +: 8] = rx_data_i;
        nxt_st.dest_addr = da;
        hcrc = crc32_byte(hcrc, rx_data_i);
        nxt_st.hash_crc = hcrc;
      end
      if (byte_idx == `DA_LAST)
      begin
        mcast = da[0];
        exact = (da == {st_ff.sta_hi, st_ff.sta_lo});
        hidx = hcrc[31:26];
        hashed = hash_bit(st_ff.hash_hi, st_ff.hash_lo, hidx);
        // the decision uses the byte just captured, so it stands one cycle later
        // mode priority
        pass = mode_pass(st_ff.ctrl, mcast, exact, hashed);
        nxt_st.addr_pass = pass;
        nxt_st.filt_done = 1'b1;
        // rejected or wake-mode frames not received
        nxt_st.filt_pass = pass & ~wake_mode;
      end
    end

    // end of frame: pattern crcs settle next cycle
    nxt_st.eval_pending = rx_valid_i & rx_eof_i;

    if (st_ff.eval_pending & wake_mode & st_ff.addr_pass)
    begin
      for (int f = 0; f < NUM_FILTERS; f++)
      begin
        cmd = st_ff.wake_words[`WORD_CMD][f*8 +: 4];
        want = st_ff.wake_words[`WORD_CRC_LO + f/2][(f%2)*16 +: 16];
        // all filters are tried; any one hit marks the frame
        // enable, type, crc
        hit = hit | filter_hit(cmd, st_ff.dest_addr[0], pat_crc[f], want);
      end
    end

    if (hit)
      nxt_st.wake_rcvd = 1'b1;
    nxt_st.irq = nxt_st.wake_rcvd & ~nxt_st.notify_pme;
    nxt_st.power_event_out = nxt_st.wake_rcvd & nxt_st.notify_pme;
  end

  // single state register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
      st_ff.wait_req <= 1'b1;
      st_ff.hash_crc <= `CRC32_INIT;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = st_ff.wait_req;
  assign filt_done_o = st_ff.filt_done;
  assign filt_pass_o = st_ff.filt_pass;
  assign irq_o = st_ff.irq;
  assign power_event_out_o = st_ff.power_event_out;

endmodule

/* design/rx_filter_consts.svh */
// constants for the receive address filter and wake-up frame detector
// Behaviour
// - perfect mode accepts only station address match
// - hash-only mode hashes multicast and physical frames
// - crc upper six bits index 64-bit table
// - index msb picks high/low, five bits pick bit
// - hash-perfect: physical exact, multicast hashed
// - inverse mode accepts only non-matching destinations
// - pass-all-multicast accepts every multicast frame
// - promiscuous accepts every frame including broadcast
// - wake enable suppresses reception, checks patterns
// - wake detect sets status, raises irq/power event
// - clearing wake enable restores normal reception
// - addressed frames checked against four filters
// - 31-bit byte mask selects crc bytes
// - eight port writes fill words in order
// - command bit 3 selects multicast or unicast
// - command bit 0 enables the filter
// - low-power state forces wake detection on
// - 16-bit crc field equality flags match
// - 8-bit offset counted from destination start
// - frames failing address filter not received
`ifndef RX_FILTER_CONSTS_SVH
`define RX_FILTER_CONSTS_SVH

// register byte offsets
`define OFS_MAC_CTRL 8'h00
`define OFS_STA_HIGH 8'h04
`define OFS_STA_LOW 8'h08
`define OFS_HASH_HIGH 8'h0c
`define OFS_HASH_LOW 8'h10
`define OFS_WAKE_CSR 8'h14
`define OFS_WAKE_LOAD 8'h18

// control register bit positions
`define CTL_HASH_PERFECT 0
`define CTL_HASH_ONLY 1
`define CTL_INVERSE 2
`define CTL_PROMISC 3
`define CTL_PASS_MCAST 4
`define CTL_WIDTH 5

// wake control/status bit positions
`define WCS_ENABLE 0
`define WCS_RECEIVED 1
`define WCS_NOTIFY_PME 2
`define WCS_LOW_POWER 3
`define WCS_PTR_LSB 4

// filter storage layout
`define WAKE_WORDS 8
`define WORD_CMD 4
`define WORD_OFFSET 5
`define WORD_CRC_LO 6
`define CMD_ENABLE 0
`define CMD_MCAST 3
`define MASK_BITS 31

// frame layout
`define DA_BYTES 8'h06
`define DA_LAST 8'h05
`define BYTE_CNT_MAX 8'hff

// crc constants
`define CRC32_POLY 32'h04c11db7
`define CRC32_INIT 32'hffffffff
`define CRC16_POLY 16'h8005
`define CRC16_INIT 16'hffff

`endif

/* design/rx_filter_pkg.sv */
// types shared by the receive filter and its pattern checkers
package rx_filter_pkg;

  // state of one wake pattern crc checker
  typedef struct packed {
    logic [15:0] crc;
  } check_state_type;

  // state of the filter top level
  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [4:0] ctrl;
    logic [15:0] sta_hi;
    logic [31:0] sta_lo;
    logic [31:0] hash_hi;
    logic [31:0] hash_lo;
    logic wake_en;
    logic wake_rcvd;
    logic notify_pme;
    logic [2:0] load_ptr;
    logic [7:0][31:0] wake_words;
    logic [7:0] byte_cnt;
    logic [47:0] dest_addr;
    logic [31:0] hash_crc;
    logic addr_pass;
    logic eval_pending;
    logic filt_done;
    logic filt_pass;
    logic irq;
    logic power_event_out;
    logic lp_meta;
    logic lp_sync;
  } filter_state_type;

endpackage

/* design/wake_pattern_check.sv */
// crc-16 accumulator over the masked bytes of one wake-up pattern
`timescale 1ns/10ps
`include "rx_filter_consts.svh"

module wake_pattern_check (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic byte_valid_i,
  input wire logic sof_i,
  input wire logic [7:0] byte_i,
  input wire logic [7:0] byte_idx_i,
  input wire logic [30:0] mask_i,
  input wire logic [7:0] offset_i,
  output logic [15:0] crc_o
);

  rx_filter_pkg::check_state_type st_ff;
  rx_filter_pkg::check_state_type nxt_st;

  // one byte of crc-16, data taken lsb first as on the wire
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb)
        r = r ^ `CRC16_POLY;
    end
    return r;
  endfunction

  // byte window test and crc step
  always_comb
  begin
    logic [15:0] base;
    logic [7:0] rel;
    base = sof_i ? `CRC16_INIT : st_ff.crc;
    rel = byte_idx_i - offset_i;
    nxt_st = st_ff;
    if (byte_valid_i)
    begin
      nxt_st.crc = base;
      if (byte_idx_i >= offset_i && rel < 8'(`MASK_BITS) && mask_i[rel[4:0]])
        nxt_st.crc = crc16_byte(base, byte_i);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      st_ff <= '{crc: `CRC16_INIT};
    else
      st_ff <= nxt_st;
  end

  assign crc_o = st_ff.crc;

endmodule

/* dv/rx_mac_src.sv */
// behavioural mac receive source that streams frame bytes
`timescale 1ns/10ps
module rx_mac_src (
  input wire logic ref_clk_i,
  output logic rx_valid_o,
  output logic rx_sof_o,
  output logic rx_eof_o,
  output logic [7:0] rx_data_o
);
  logic [7:0] buf_q[$];
  // idle level at time zero
  initial
  begin
    rx_valid_o = 1'b0;
    rx_sof_o = 1'b0;
    rx_eof_o = 1'b0;
    rx_data_o = 8'h00;
  end
  // idle cycles carry the inverted last byte so stale data never looks valid
  task automatic send(input bit slow);
    int n;
    n = buf_q.size();
    for (int k = 0; k < n; k++)
    begin
      @(posedge ref_clk_i);
      rx_valid_o <= 1'b1;
      rx_sof_o <= (k == 0);
      rx_eof_o <= (k == n - 1);
      rx_data_o <= buf_q[k];
      if (slow && k[0])
      begin
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~buf_q[k];
      end
    end
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    rx_eof_o <= 1'b0;
    rx_data_o <= ~buf_q[n - 1];
  endtask
endmodule

/* dv/rx_filter_monitor.sv */
// port-level assertions for the address filter and wake detector
`timescale 1ns/10ps
module rx_filter_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic rx_valid_i,
  input wire logic rx_eof_i,
  input wire logic low_power_i,
  input wire logic filt_done_o,
  input wire logic filt_pass_o,
  input wire logic irq_o,
  input wire logic power_event_out_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_ack;
    $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  property p_rd_hold;
    $changed(avs_readdata_o) |-> $past(avs_read_i);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_done_pulse;
    filt_done_o |=> !filt_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("decision pulse long");
  property p_done_cause;
    filt_done_o |-> $past(rx_valid_i);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("decision without byte");
  property p_lp_block;
    low_power_i [*4] ##0 filt_done_o |-> !filt_pass_o;
  endproperty
  a_lp_block: assert property (p_lp_block) else $error("reception in wake mode");
  property p_one_notify;
    !(irq_o && power_event_out_o);
  endproperty
  a_one_notify: assert property (p_one_notify) else $error("both notifications");
  property p_wake_time;
    $rose(irq_o || power_event_out_o) |-> $past(rx_valid_i && rx_eof_i, 2);
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("wake flag mistimed");
  property p_clear;
    $fell(irq_o || power_event_out_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("wake flag dropped alone");
  c_pass: cover property (filt_done_o && filt_pass_o);
  c_irq: cover property ($rose(irq_o));
  c_pme: cover property ($rose(power_event_out_o));
endmodule

bind rx_address_filter_wake_detect rx_filter_monitor mon (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .avs_readdata_o(avs_readdata_o),
  .rx_valid_i(rx_valid_i),
  .rx_eof_i(rx_eof_i),
  .low_power_i(low_power_i),
  .filt_done_o(filt_done_o),
  .filt_pass_o(filt_pass_o),
  .irq_o(irq_o),
  .power_event_out_o(power_event_out_o)
);

/* dv/tb_top.sv */
// self-checking bench for the receive filter and wake detector
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, r;
  logic wreq, rxv, rxs, rxe, done, pass, irq, power_event_out, lpass, ew, wm, en;
  logic [7:0] rxd;
  logic lp = 1'b0;
  int n_mismatch = 0, tests_run = 0, seed = 47, dcnt = 0, d0;
  logic [47:0] sta;
  logic [63:0] htab;
  logic [4:0] ctl;
  logic [7:0] fr[48], sv[48], ofs[4], cmd[4];
  logic [30:0] msk[4];
  logic [15:0] crc[4];
  logic [4:0] modes[8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h12, 5'h0d};
  // 250 mhz clock
  always #2 ref_clk_i = ~ref_clk_i;
  rx_mac_src src (.ref_clk_i(ref_clk_i), .rx_valid_o(rxv), .rx_sof_o(rxs), .rx_eof_o(rxe),
    .rx_data_o(rxd));
  rx_address_filter_wake_detect dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .rx_valid_i(rxv), .rx_sof_i(rxs), .rx_eof_i(rxe), .rx_data_i(rxd), .low_power_i(lp),
    .filt_done_o(done), .filt_pass_o(pass), .irq_o(irq), .power_event_out_o(power_event_out));
  // capture each address decision as it pulses
  always @(posedge ref_clk_i)
    if (done === 1'b1)
    begin
      dcnt++;
      lpass = pass;
    end
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    for (k = 0; k < 16; k++)
    begin
      @(posedge ref_clk_i);
      if (wreq === 1'b0)
        break;
    end
    if (k == 16)
    begin
      n_mismatch++;
      give_verdict();
    end
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic [31:0] c32(logic [31:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c[31] ^ b[i]) ? (c << 1) ^ 32'h04c11db7 : c << 1;
    return c;
  endfunction
  function automatic logic [15:0] wcrc(int f);
    logic [15:0] c;
    c = 16'hffff;
    for (int j = 0; j < 31; j++)
      for (int i = 0; i < 8 && msk[f][j]; i++)
        c = (c[15] ^ fr[ofs[f] + j][i]) ? (c << 1) ^ 16'h8005 : c << 1;
    return c;
  endfunction
  function automatic logic [47:0] da();
    return {fr[5], fr[4], fr[3], fr[2], fr[1], fr[0]};
  endfunction
  function automatic logic fpass(logic [47:0] a);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int k = 0; k < 6; k++)
      c = c32(c, a[k*8+:8]);
    if (ctl[3] || (ctl[4] && a[0]))
      return 1'b1;
    if (ctl[2])
      return a != sta;
    if (ctl[1] || (ctl[0] && a[0]))
      return htab[c[31:26]];
    return a == sta;
  endfunction
  // any enabled filter of the right type
  function automatic logic fwake();
    logic m;
    m = 1'b0;
    for (int i = 0; i < 4; i++)
      m |= cmd[i][0] && cmd[i][3] == fr[0][0] && wcrc(i) == crc[i];
    return m && fpass(da());
  endfunction
  // DA kinds: station, random unicast, multicast, broadcast
  task automatic mk(int kd);
    foreach (fr[k])
      fr[k] = (kd == 0 && k < 6) ? sta[k*8+:8] : 8'($random(seed));
    fr[0][0] = (kd == 2);
    if (kd == 3)
      for (int k = 0; k < 6; k++)
        fr[k] = 8'hff;
  endtask
  task automatic frame(input bit slow);
    src.buf_q = {};
    foreach (fr[k])
      src.buf_q.push_back(fr[k]);
    d0 = dcnt;
    src.send(slow);
    repeat (4) @(posedge ref_clk_i);
    `CHK(dcnt - d0, 1)
  endtask
  // eight words in order, bit 31 of masks written as one
  task automatic load();
    for (int w = 0; w < 8; w++)
      bus(8'h18, 1'b1, w < 4 ? {1'b1, msk[w]} : w == 4 ? {cmd[3], cmd[2], cmd[1], cmd[0]} :
        w == 5 ? {ofs[3], ofs[2], ofs[1], ofs[0]} : w == 6 ? {crc[1], crc[0]} : {crc[3], crc[2]});
  endtask
  // hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    n_mismatch++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    bus(8'h18, 1'b0, 32'h0);
    `CHK(r, 32'h0)
    bus(8'h1c, 1'b0, 32'h0);
    `CHK(r, 32'h0)
    sta = 48'({$random(seed), $random(seed)});
    sta[0] = 1'b0;
    htab = {$random(seed), $random(seed)};
    bus(8'h04, 1'b1, {16'h0, sta[47:32]});
    bus(8'h08, 1'b1, sta[31:0]);
    bus(8'h0c, 1'b1, htab[63:32]);
    bus(8'h10, 1'b1, htab[31:0]);
    for (int t = 0; t < 32; t++)
    begin
      ctl = modes[t % 8];
      bus(8'h00, 1'b1, {27'h0, ctl});
      mk(t / 8);
      frame(t % 2);
      `CHK(lpass, fpass(da()))
    end
    mk(0);
    sv = fr;
    for (int i = 0; i < 4; i++)
    begin
      msk[i] = 31'($random(seed));
      ofs[i] = 8'h0d + i;
      cmd[i] = (i == 0) ? 8'h09 : (i == 2) ? 8'h00 : 8'h01;
      crc[i] = wcrc(i) ^ (i == 1);
    end
    load();
    // wake variants with both notify targets
    for (int v = 0; v < 6; v++)
    begin
      fr = sv;
      ctl = (v == 2) ? 5'h10 : 5'h00;
      en = (v < 3 || v == 5);
      if (v == 1)
        for (int k = 12; k < 48; k++)
          fr[k] = ~fr[k];
      fr[0][0] = (v == 2);
      bus(8'h00, 1'b1, {27'h0, ctl});
      if (v == 5)
      begin
        cmd[3] = 8'h00;
        load();
      end
      bus(8'h14, 1'b1, {29'h0, v[0], 1'b1, en});
      lp <= (v == 3);
      frame(1'b0);
      wm = en || lp;
      ew = wm && fwake();
      `CHK(lpass, !wm && fpass(da()))
      `CHK(irq, ew && !v[0])
      `CHK(power_event_out, ew && v[0])
      bus(8'h14, 1'b0, 32'h0);
      `CHK(r[1], ew)
    end
    give_verdict();
  end
endmodule
